// >>> src/ldma_arbiter.sv
`timescale 1ns/1ns
`include "ldma_regs.svh"
module ldma_arbiter (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  input  wire ldma_pkg::ldma_policy_t i_policy,
  input  wire logic                   i_ignore_lock_end,
  input  wire logic                   i_first_cpu_request_n,
  input  wire logic                   i_first_cpu_lock_n,
  input  wire logic                   i_first_cpu_lock_end_n,
  input  wire logic                   i_first_cpu_transfer_in_progress_n,
  input  wire logic                   i_second_cpu_request_n,
  input  wire logic                   i_second_cpu_lock_n,
  input  wire logic                   i_second_cpu_lock_end_n,
  input  wire logic                   i_bus_busy_n,
  output logic                        o_first_cpu_grant_n,
  output logic                        o_second_cpu_grant_n,
  output ldma_pkg::ldma_state_t       o_state
);
  import ldma_pkg::*;

  // State, grant registers
  ldma_state_t state_q;
  ldma_state_t state_d;
  logic        gnt1_q;
  logic        gnt1_d;
  logic        gnt2_q;
  logic        gnt2_d;

  // Async DMA path: synchronised request and lock
  logic        req2_s_n;
  logic        lock2_s_n;
  logic        req2_f_n;
  logic        lock2_f_n;
  logic        req2_stab;
  logic        lock2_stab;

  // Policy decode
  wire is_fair = (i_policy == `LDMA_POL_FAIR);
  wire is_prio = (i_policy == `LDMA_POL_PRIO);
  wire is_async = (i_policy == `LDMA_POL_ADMA_LO) || (i_policy == `LDMA_POL_ADMA_HI);
  wire second_lo = (i_policy == `LDMA_POL_SDMA_LO) || (i_policy == `LDMA_POL_ADMA_LO);

  ldma_sync u_sync_req (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async_n (i_second_cpu_request_n),
    .o_sync_n  (req2_s_n)
  );
  ldma_sync u_sync_lock (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async_n (i_second_cpu_lock_n),
    .o_sync_n  (lock2_s_n)
  );
  ldma_stable u_stab_req (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_level_n    (req2_s_n),
    .o_stable     (req2_stab),
    .o_asserted_n (req2_f_n)
  );
  ldma_stable u_stab_lock (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_level_n    (lock2_s_n),
    .o_stable     (lock2_stab),
    .o_asserted_n (lock2_f_n)
  );

  // Effective second-party signals
  wire req2  = is_async ? !req2_f_n  : !i_second_cpu_request_n;
  wire lock2 = is_async ? !lock2_f_n : !i_second_cpu_lock_n;
  // hold state while async inputs unsettled
  wire hold = is_async && !(req2_stab && lock2_stab);
  wire req1  = !i_first_cpu_request_n;
  // under priority, request stands in for lock on first
  wire lock1 = !i_first_cpu_lock_n || (is_prio && req1);
  // lock end forced negated when ignored
  wire lend1 = !i_ignore_lock_end && !i_first_cpu_lock_end_n;
  wire lend2 = !i_ignore_lock_end && !i_second_cpu_lock_end_n;
  wire busy  = !i_bus_busy_n;
  // async DMA sees processor tip or busy
  wire cpu_idle = i_bus_busy_n && (!is_async || i_first_cpu_transfer_in_progress_n);

  // Yield decisions from owner 1 to 2
  // fairness yields to other requester
  // priority yields only without own request
  // low DMA only without processor request
  // low async DMA only when processor idle
  wire want12 = is_fair ? req2
              : (is_prio || second_lo) ? (req2 && !req1 && (!is_async || !busy))
              : req2;
  // locked owner kept until lock end
  wire lock_ok1 = !lock1 || lend1;
  // Owner 2 gives back
  // under fair and priority, second outranks first only while locked
  wire want21 = is_fair ? req1
              : is_prio ? (req1 && (!lock2 || lend2))
              : (second_lo ? req1 : 1'b0) || !req2;
  wire lock_ok2 = !lock2 || lend2 || !is_fair;

  // Next state
  // unlocked request moves to handover
  // fresh lock in handover returns grant (back to owner 2 only under fairness)
  // new owner may hand back next clock
  always_comb begin
    state_d = state_q;
    if (!hold) begin
      case (state_q)
        LDMA_OWN1: begin
          if (want12 && lock_ok1) state_d = LDMA_HAND12;
        end
        LDMA_HAND12: begin
          if (lock1 && !lend1) state_d = LDMA_OWN1;
          else if (cpu_idle) state_d = LDMA_OWN2;
        end
        LDMA_OWN2: begin
          if (want21 && lock_ok2) state_d = LDMA_HAND21;
        end
        LDMA_HAND21: begin
          if (is_fair && lock2 && !lend2) state_d = LDMA_OWN2;
          else if (i_bus_busy_n) state_d = LDMA_OWN1;
        end
        default: state_d = LDMA_OWN1;
      endcase
    end
  end

  // grant dropped for the handover entry edge
  // default owner gets grant in own state
  wire enter_hand = (state_d != state_q) && ((state_d == LDMA_HAND12) || (state_d == LDMA_HAND21));
  // owner state waits one edge while other grant still on
  assign gnt1_d = ((state_d == LDMA_OWN1) && !gnt2_q)
                || ((state_d == LDMA_HAND21) && !enter_hand);
  assign gnt2_d = ((state_d == LDMA_OWN2) && !gnt1_q)
                || ((state_d == LDMA_HAND12) && !enter_hand);

  // sync reset to default master grant
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= LDMA_OWN1;
      gnt1_q  <= 1'b1;
      gnt2_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      gnt1_q  <= gnt1_d;
      gnt2_q  <= gnt2_d;
    end
  end

  // Active-low grants, straight from flops
  assign o_first_cpu_grant_n  = !gnt1_q;
  assign o_second_cpu_grant_n = !gnt2_q;
  assign o_state              = state_q;
endmodule // ldma_arbiter

// >>> src/ldma_regs.svh
`ifndef LDMA_REGS_SVH
`define LDMA_REGS_SVH

// Policy encodings on i_policy
`define LDMA_POL_FAIR      3'h0
`define LDMA_POL_PRIO      3'h1
`define LDMA_POL_SDMA_LO   3'h2
`define LDMA_POL_SDMA_HI   3'h3
`define LDMA_POL_ADMA_LO   3'h4
`define LDMA_POL_ADMA_HI   3'h5
// Synchroniser stages before a level counts as seen
`define LDMA_SYNC_STAGES   2
// Active-low asserted and negated levels
`define LDMA_ASSERTED      1'h0
`define LDMA_NEGATED       1'h1

`endif

// >>> src/ldma_pkg.sv
package ldma_pkg;
  // Arbiter states: owner held, handover, new owner, gap
  typedef enum logic [2:0] {
    LDMA_OWN1,
    LDMA_HAND12,
    LDMA_OWN2,
    LDMA_HAND21,
    LDMA_GAP
  } ldma_state_t;
  // Arbitration policy selector
  typedef logic [2:0] ldma_policy_t;
endpackage

// >>> src/ldma_sync.sv
`timescale 1ns/1ns
`include "ldma_regs.svh"
// Two-flop synchroniser; output reset to negated (high)
module ldma_sync (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_async_n,
  output logic      o_sync_n
);
  // First and second stage
  logic meta_q;
  logic sync_q;

  // Meta flop feeds only the second flop
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_q <= `LDMA_NEGATED;
      sync_q <= `LDMA_NEGATED;
    end else begin
      meta_q <= i_async_n;
      sync_q <= meta_q;
    end
  end

  assign o_sync_n = sync_q;
endmodule // ldma_sync

// >>> src/ldma_stable.sv
`timescale 1ns/1ns
`include "ldma_regs.svh"
// Flags a synchronised low level held for two rising edges
module ldma_stable (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_level_n,
  output logic      o_stable,
  output logic      o_asserted_n
);
  // Previous sample of the level
  logic prev_q;

  // Keep last sample
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      prev_q <= `LDMA_NEGATED;
    end else begin
      prev_q <= i_level_n;
    end
  end

  // Stable when two samples agree
  assign o_stable     = (prev_q == i_level_n);
  assign o_asserted_n = prev_q | i_level_n;
endmodule // ldma_stable

// >>> tb/ldma_arbiter_sva.sv
`timescale 1ns/1ns
`include "ldma_regs.svh"
// Grant and state checks at the arbiter ports
module ldma_arbiter_chk (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_n,
  input wire ldma_pkg::ldma_policy_t i_policy,
  input wire logic                   i_first_cpu_request_n,
  input wire logic                   i_first_cpu_lock_n,
  input wire logic                   i_first_cpu_lock_end_n,
  input wire logic                   i_second_cpu_request_n,
  input wire logic                   i_bus_busy_n,
  input wire logic                   o_first_cpu_grant_n,
  input wire logic                   o_second_cpu_grant_n,
  input wire ldma_pkg::ldma_state_t  o_state
);
  import ldma_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  wire fair_w = (i_policy == `LDMA_POL_FAIR);  // Fairness policy
  wire own1_w = (o_state == LDMA_OWN1);        // First master owns
  AST_NO_BOTH: assert property (o_first_cpu_grant_n || o_second_cpu_grant_n)
    else $error("both grants on");
  AST_GAP_TO2: assert property ($fell(o_second_cpu_grant_n) |-> $past(o_first_cpu_grant_n))
    else $error("no gap before grant two");
  AST_GAP_TO1: assert property ($fell(o_first_cpu_grant_n) |-> $past(o_second_cpu_grant_n))
    else $error("no gap before grant one");
  AST_HAND_BUSY: assert property (o_state == LDMA_HAND12 && !i_bus_busy_n |=> o_state != LDMA_OWN2)
    else $error("left handover while busy");
  AST_LOCK_HOLD: assert property (fair_w && own1_w && !i_first_cpu_lock_n && i_first_cpu_lock_end_n |=> own1_w)
    else $error("locked owner lost bus");
  AST_FAIR_HAND: assert property (fair_w && own1_w && !i_second_cpu_request_n && i_first_cpu_lock_n |=> o_state == LDMA_HAND12)
    else $error("no handover");
  AST_PRIO_HOLD: assert property (i_policy == `LDMA_POL_PRIO && own1_w && !i_first_cpu_request_n |=> own1_w)
    else $error("priority owner lost bus");
  AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> own1_w && !o_first_cpu_grant_n && o_second_cpu_grant_n)
    else $error("bad reset state");
  // Main scenarios reached
  cover property (o_state == LDMA_OWN2);
  cover property (o_state == LDMA_HAND21);
  cover property ($fell(o_first_cpu_grant_n));
endmodule  // ldma_arbiter_chk

// >>> tb/ldma_cpu_model.sv
`timescale 1ns/1ns
// Processor model: requests on command, runs three-clock bus cycles
module ldma_cpu_model (
  input  wire logic i_clk_sys,
  input  wire logic i_grant_n,
  input  wire logic i_bus_busy_n,
  input  wire logic i_want,
  input  wire logic i_lock,
  output logic      o_request_n,
  output logic      o_lock_n,
  output logic      o_busy_n
);
  logic [1:0] left_q = 2'h0;  // Clocks left in bus cycle
  assign o_request_n = !(i_want || i_lock);
  assign o_lock_n    = !i_lock;
  assign o_busy_n    = (left_q == 2'h0);
  // take bus when granted and idle
  always @(posedge i_clk_sys) begin
    if (!o_busy_n) left_q <= left_q - 2'h1;
    else if (!i_grant_n && i_bus_busy_n && !o_request_n) left_q <= 2'h3;
  end
endmodule  // ldma_cpu_model

// >>> tb/ldma_arbiter_tb.sv
`timescale 1ns/1ns
`include "ldma_regs.svh"
// Bench: two processor models around the arbiter
module ldma_arbiter_tb;
  import ldma_pkg::*;
  logic         clk = 1'b0;                       // Bus clock
  logic         rst_n;                            // Sync reset
  logic         want1, lock1, le1, want2, lock2;  // Model commands
  logic         req1_n, lk1_n, bsy1_n, req2_n, lk2_n, bsy2_n, g1_n, g2_n;
  ldma_policy_t pol;                              // Policy select
  ldma_state_t  st;                               // Arbiter state
  logic         ign = 1'b0;                       // Lock end ignore
  int           n_fail = 0;
  int           checks_done = 0;
  wire          busy_n = bsy1_n & bsy2_n;         // Wired busy line
  always #25 clk = ~clk;
  ldma_arbiter i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_policy(pol),
    .i_ignore_lock_end(ign), .i_first_cpu_request_n(req1_n), .i_first_cpu_lock_n(lk1_n),
    .i_first_cpu_lock_end_n(le1), .i_first_cpu_transfer_in_progress_n(bsy1_n),
    .i_second_cpu_request_n(req2_n), .i_second_cpu_lock_n(lk2_n),
    .i_second_cpu_lock_end_n(1'b1), .i_bus_busy_n(busy_n),
    .o_first_cpu_grant_n(g1_n), .o_second_cpu_grant_n(g2_n), .o_state(st));
  ldma_cpu_model i_cpu1 (.i_clk_sys(clk), .i_grant_n(g1_n), .i_bus_busy_n(busy_n),
    .i_want(want1), .i_lock(lock1), .o_request_n(req1_n), .o_lock_n(lk1_n), .o_busy_n(bsy1_n));
  ldma_cpu_model i_cpu2 (.i_clk_sys(clk), .i_grant_n(g2_n), .i_bus_busy_n(busy_n),
    .i_want(want2), .i_lock(lock2), .o_request_n(req2_n), .o_lock_n(lk2_n), .o_busy_n(bsy2_n));
  // Compare and count
  task automatic chk(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %b not %b", $time, seen, exp);
    end
  endtask
  // Flags: want1 lock1 lockend1_n want2 lock2
  task automatic drv(input ldma_policy_t p, input logic [4:0] f);
    @(negedge clk);
    pol = p;
    {want1, lock1, le1, want2, lock2} = f;
  endtask
  // Wait up to 40 clocks for a grant, then check it
  task automatic wg(input logic two);
    int i;
    for (i = 0; i < 40 && (two ? g2_n : g1_n) !== 1'b0; i++) @(negedge clk);
    chk(two ? g2_n : g1_n, 1'b0);
  endtask
  // Higher master keeps bus, lower gets it once idle
  task automatic t_low(input ldma_policy_t p);
    drv(p, 5'h16);
    wg(1'b0);
    repeat (8) @(negedge clk);
    chk(g2_n, 1'b1);
    drv(p, 5'h06);
    wg(1'b1);
    drv(p, 5'h04);
    $display("low priority test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
  initial begin
    pol = `LDMA_POL_FAIR;
    {want1, lock1, le1, want2, lock2} = 5'h04;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk(g1_n, 1'b0);
    chk(st === LDMA_OWN1, 1'b1);
    $display("reset test done");
    drv(`LDMA_POL_FAIR, 5'h16);
    wg(1'b1);
    wg(1'b0);
    drv(`LDMA_POL_FAIR, 5'h0E);
    wg(1'b0);
    repeat (8) @(negedge clk);
    chk(g2_n, 1'b1);
    drv(`LDMA_POL_FAIR, 5'h0A);
    ign = 1'b1;
    repeat (8) @(negedge clk);
    chk(g2_n, 1'b1);
    ign = 1'b0;
    drv(`LDMA_POL_FAIR, 5'h02);
    wg(1'b1);
    $display("fair test done");
    t_low(`LDMA_POL_PRIO);
    t_low(`LDMA_POL_SDMA_LO);
    drv(`LDMA_POL_SDMA_HI, 5'h16);
    wg(1'b1);
    drv(`LDMA_POL_SDMA_HI, 5'h04);
    wg(1'b0);
    drv(`LDMA_POL_ADMA_HI, 5'h06);
    drv(`LDMA_POL_ADMA_HI, 5'h04);
    repeat (8) @(negedge clk);
    chk(g2_n, 1'b1);
    drv(`LDMA_POL_ADMA_HI, 5'h06);
    wg(1'b1);
    $display("dma test done");
    end_of_test;
  end
endmodule  // ldma_arbiter_tb

bind ldma_arbiter ldma_arbiter_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_policy(i_policy), .i_first_cpu_request_n(i_first_cpu_request_n),
  .i_first_cpu_lock_n(i_first_cpu_lock_n), .i_first_cpu_lock_end_n(i_first_cpu_lock_end_n),
  .i_second_cpu_request_n(i_second_cpu_request_n), .i_bus_busy_n(i_bus_busy_n),
  .o_first_cpu_grant_n(o_first_cpu_grant_n), .o_second_cpu_grant_n(o_second_cpu_grant_n),
  .o_state(o_state));
